// ---- hdl/smcr_control_regs.v ----
// Control registers of the sense monitor with converter sequencing and the fault latch.
// Function
// - Select codes 0-2 sample sense at 1x/4x/8x.
// - Code 3 common-mode input, code 4 output pin.
// - Code 5 set reference, code 6 die temperature.
// - Code 7 sweeps all channels every 2ms.
// - Power-down bit 3 shuts down, resets clear.
// - Writing latch clear bit 4 releases latch.
// - Function 000 leaves output plainly following amplifier.
// - Comparator function qualifies, latches high, then retries.
// - Amplifier function regulates, latches high, then retries.
// - Inverting variant reverses timed output polarity.
// - Qualify delay 1ms clear, 100us set.
// - Retry interval 50ms clear, 10ms set.
// - Reset forces both registers to defaults.
// - Retry expiry clears latch, restarts the cycle.
`timescale 1ns/1ps
`include "smcr_defines.vh"
module smcr_control_regs #(
  parameter INVERTING = 0,
  parameter TW = 24,
  parameter QUAL_LONG_CYC = `SMCR_QUAL_LONG_CYC,
  parameter QUAL_SHORT_CYC = `SMCR_QUAL_SHORT_CYC,
  parameter RETRY_LONG_CYC = `SMCR_RETRY_LONG_CYC,
  parameter RETRY_SHORT_CYC = `SMCR_RETRY_SHORT_CYC,
  parameter SWEEP_CYC = `SMCR_SWEEP_CYC
) (
  // Clock and power-on reset.
  input wire clk_i,
  input wire nrst_i,
  // Register port from the serial slave engine.
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Converter handshake.
  output wire conv_start_o,
  output reg [2:0] conv_channel_o,
  output reg [1:0] conv_gain_o,
  input wire conv_done_i,
  // Analog trip comparison, sense output above set reference.
  input wire trip_i,
  // Analog and output stage control.
  output reg power_down_o,
  output reg out_force_en_o,
  output reg out_force_level_o,
  output reg latched_o
);

  // Sequencer states of the timed output functions.
  localparam ST_QUAL = 1'b0;
  localparam ST_LATCH = 1'b1;
  // Converter sequencer states.
  localparam CV_IDLE = 2'h0;
  localparam CV_BUSY = 2'h1;
  localparam CV_WAIT = 2'h2;

  reg [7:0] ctrl_one_reg; // Channel, power-down and function fields; clear bit always 0.
  reg [7:0] fault_delay_reg; // Only the two delay selects are kept.
  reg latch_clear_reg; // One-cycle pulse from a write of the clear bit.
  reg trip_meta_reg; // First synchroniser stage.
  reg trip_sync_reg; // Second synchroniser stage.
  reg state_reg; // Qualify or latched.
  reg [1:0] cv_state_reg; // Converter sequencer state.
  reg [2:0] sweep_idx_reg; // Channel index in a sweep.
  reg [1:0] last_gain_reg; // Last sense gain chosen.
  reg start_reg; // Start pulse to the converter.
  reg [2:0] chan_next;
  reg [1:0] gain_next;

  wire [2:0] chan_sel = ctrl_one_reg[`SMCR_CHAN_MSB:`SMCR_CHAN_LSB];
  wire [2:0] func_sel = ctrl_one_reg[`SMCR_FUNC_MSB:`SMCR_FUNC_LSB];
  wire timed_func = (func_sel == `SMCR_FUNC_CMP_LATCH) || (func_sel == `SMCR_FUNC_AMP_LATCH);
  wire sweeping = (chan_sel == `SMCR_SEL_SWEEP);
  wire wr_one = reg_wr_i && (reg_addr_i == `SMCR_ADDR_CTRL_ONE);
  wire wr_two = reg_wr_i && (reg_addr_i == `SMCR_ADDR_FAULT_DELAY);
  wire pol = (INVERTING != 0);

  // Decodes a non-sweep select code into a converter channel.
  function [2:0] chan_of;
    input [2:0] sel;
    begin
      case (sel)
        `SMCR_SEL_COMMON: chan_of = `SMCR_CH_COMMON;
        `SMCR_SEL_OUTPIN: chan_of = `SMCR_CH_OUTPIN;
        `SMCR_SEL_SETREF: chan_of = `SMCR_CH_SETREF;
        `SMCR_SEL_TEMP: chan_of = `SMCR_CH_TEMP;
        default: chan_of = `SMCR_CH_SENSE;
      endcase
    end
  endfunction

  // Register writes; reset forces the defaults.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_one_reg <= `SMCR_CTRL_ONE_RST;
      fault_delay_reg <= `SMCR_FAULT_DELAY_RST;
      latch_clear_reg <= 1'b0;
    end else begin
      latch_clear_reg <= wr_one && reg_wdata_i[`SMCR_LCLR_BIT];
      if (wr_one) begin
        // The clear bit is never stored, so it reads back as zero.
        ctrl_one_reg <= reg_wdata_i & ~(8'h01 << `SMCR_LCLR_BIT);
      end
      if (wr_two) begin
        // Unused bits are ignored and read as zero.
        fault_delay_reg <= reg_wdata_i & ((8'h01 << `SMCR_QUAL_SEL_BIT) |
                                          (8'h01 << `SMCR_RETRY_SEL_BIT));
      end
    end
  end

  // Registered read data; unmapped addresses read zero.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SMCR_ADDR_CTRL_ONE: reg_rdata_o <= ctrl_one_reg;
        `SMCR_ADDR_FAULT_DELAY: reg_rdata_o <= fault_delay_reg;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Two-stage synchroniser for the analog trip level.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trip_meta_reg <= 1'b0;
      trip_sync_reg <= 1'b0;
    end else begin
      trip_meta_reg <= trip_i;
      trip_sync_reg <= trip_meta_reg;
    end
  end

  // Delay selection, counted in clock cycles.
  wire [TW-1:0] qual_load = fault_delay_reg[`SMCR_QUAL_SEL_BIT] ?
    QUAL_SHORT_CYC[TW-1:0] - {{(TW-1){1'b0}}, 1'b1} :
    QUAL_LONG_CYC[TW-1:0] - {{(TW-1){1'b0}}, 1'b1};
  wire [TW-1:0] retry_load = fault_delay_reg[`SMCR_RETRY_SEL_BIT] ?
    RETRY_SHORT_CYC[TW-1:0] - {{(TW-1){1'b0}}, 1'b1} :
    RETRY_LONG_CYC[TW-1:0] - {{(TW-1){1'b0}}, 1'b1};

  wire fault_expired;
  wire qual_done = (state_reg == ST_QUAL) && trip_sync_reg && fault_expired;
  wire retry_done = (state_reg == ST_LATCH) && fault_expired;
  // Reload while qualifying with the trip absent, on every state change and when untimed.
  wire fault_load = !timed_func || latch_clear_reg || qual_done || retry_done ||
                    ((state_reg == ST_QUAL) && !trip_sync_reg);
  wire [TW-1:0] fault_load_val = qual_done ? retry_load : qual_load;

  // Shared timer for the qualify delay and the retry interval.
  smcr_interval_timer #(
    .WIDTH(TW)
  ) u_fault_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(fault_load),
    .load_val_i(fault_load_val),
    .run_i(1'b1),
    .expired_o(fault_expired)
  );

  // Qualify, latch and retry sequence.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_QUAL;
    end else begin
      case (state_reg)
        ST_QUAL: begin
          // A qualify that completes in the cycle of a clear still latches; the set wins.
          if (timed_func && qual_done) begin
            state_reg <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          if (!timed_func || latch_clear_reg || retry_done) begin
            state_reg <= ST_QUAL;
          end
        end
        default: state_reg <= ST_QUAL;
      endcase
    end
  end

  // Output stage control from the function and sequence state.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_force_en_o <= 1'b0;
      out_force_level_o <= 1'b0;
      latched_o <= 1'b0;
      power_down_o <= 1'b0;
    end else begin
      power_down_o <= ctrl_one_reg[`SMCR_PWRDN_BIT];
      latched_o <= timed_func && (state_reg == ST_LATCH);
      if (!timed_func) begin
        out_force_en_o <= 1'b0;
        out_force_level_o <= pol;
      end else if (state_reg == ST_LATCH) begin
        out_force_en_o <= 1'b1;
        out_force_level_o <= 1'b1 ^ pol;
      end else if (func_sel == `SMCR_FUNC_CMP_LATCH) begin
        out_force_en_o <= 1'b1;
        out_force_level_o <= 1'b0 ^ pol;
      end else begin
        // The amplifier regulates freely while qualifying.
        out_force_en_o <= 1'b0;
        out_force_level_o <= pol;
      end
    end
  end

  // Sweep period timer.
  wire sweep_expired;
  wire sweep_load = !sweeping || sweep_expired;
  smcr_interval_timer #(
    .WIDTH(TW)
  ) u_sweep_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(sweep_load),
    .load_val_i(SWEEP_CYC[TW-1:0] - {{(TW-1){1'b0}}, 1'b1}),
    .run_i(1'b1),
    .expired_o(sweep_expired)
  );

  // Channel and gain for the next conversion.
  always @* begin
    gain_next = last_gain_reg;
    chan_next = chan_of(chan_sel);
    if (sweeping) begin
      chan_next = sweep_idx_reg;
    end else if (chan_sel <= `SMCR_SEL_GAIN8) begin
      gain_next = chan_sel[1:0];
    end
  end

  // Converter sequencer: back-to-back in single mode, one pass per period in sweep.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cv_state_reg <= CV_IDLE;
      sweep_idx_reg <= `SMCR_CH_SENSE;
      last_gain_reg <= 2'h0;
      start_reg <= 1'b0;
      conv_channel_o <= `SMCR_CH_SENSE;
      conv_gain_o <= 2'h0;
    end else begin
      start_reg <= 1'b0;
      last_gain_reg <= gain_next;
      case (cv_state_reg)
        CV_IDLE: begin
          if (!ctrl_one_reg[`SMCR_PWRDN_BIT]) begin
            start_reg <= 1'b1;
            conv_channel_o <= chan_next;
            conv_gain_o <= gain_next;
            cv_state_reg <= CV_BUSY;
          end
        end
        CV_BUSY: begin
          if (conv_done_i) begin
            if (sweeping && (sweep_idx_reg != `SMCR_CH_TEMP)) begin
              sweep_idx_reg <= sweep_idx_reg + 3'h1;
              cv_state_reg <= CV_IDLE;
            end else if (sweeping) begin
              sweep_idx_reg <= `SMCR_CH_SENSE;
              cv_state_reg <= CV_WAIT;
            end else begin
              sweep_idx_reg <= `SMCR_CH_SENSE;
              cv_state_reg <= CV_IDLE;
            end
          end
        end
        CV_WAIT: begin
          if (!sweeping || sweep_expired) begin
            cv_state_reg <= CV_IDLE;
          end
        end
        default: cv_state_reg <= CV_IDLE;
      endcase
    end
  end

  assign conv_start_o = start_reg;

endmodule // smcr_control_regs

// ---- hdl/smcr_defines.vh ----
// Register map, field positions, reset values and timing figures of the monitor control block.
`ifndef SMCR_DEFINES_VH
`define SMCR_DEFINES_VH

// Register addresses on the serial register port.
`define SMCR_ADDR_CTRL_ONE 8'h0a
`define SMCR_ADDR_FAULT_DELAY 8'h0b

// Reset values of both control registers.
`define SMCR_CTRL_ONE_RST 8'h00
`define SMCR_FAULT_DELAY_RST 8'h00

// Field positions in the first control register.
`define SMCR_CHAN_LSB 0
`define SMCR_CHAN_MSB 2
`define SMCR_PWRDN_BIT 3
`define SMCR_LCLR_BIT 4
`define SMCR_FUNC_LSB 5
`define SMCR_FUNC_MSB 7

// Field positions in the fault delay register.
`define SMCR_RETRY_SEL_BIT 2
`define SMCR_QUAL_SEL_BIT 3

// Channel select codes.
`define SMCR_SEL_GAIN1 3'h0
`define SMCR_SEL_GAIN4 3'h1
`define SMCR_SEL_GAIN8 3'h2
`define SMCR_SEL_COMMON 3'h3
`define SMCR_SEL_OUTPIN 3'h4
`define SMCR_SEL_SETREF 3'h5
`define SMCR_SEL_TEMP 3'h6
`define SMCR_SEL_SWEEP 3'h7

// Converter channel codes driven to the converter.
`define SMCR_CH_SENSE 3'h0
`define SMCR_CH_COMMON 3'h1
`define SMCR_CH_OUTPIN 3'h2
`define SMCR_CH_SETREF 3'h3
`define SMCR_CH_TEMP 3'h4

// Output function codes.
`define SMCR_FUNC_PLAIN 3'h0
`define SMCR_FUNC_AMP_LATCH 3'h3
`define SMCR_FUNC_CMP_LATCH 3'h7

// Timing figures as printed, and the clock rate.
`define SMCR_CLK_MHZ 250
`define SMCR_QUAL_LONG_US 1000
`define SMCR_QUAL_SHORT_US 100
`define SMCR_RETRY_LONG_MS 50
`define SMCR_RETRY_SHORT_MS 10
`define SMCR_SWEEP_MS 2

// Cycle counts derived from the figures above.
`define SMCR_QUAL_LONG_CYC (`SMCR_QUAL_LONG_US * `SMCR_CLK_MHZ)
`define SMCR_QUAL_SHORT_CYC (`SMCR_QUAL_SHORT_US * `SMCR_CLK_MHZ)
`define SMCR_RETRY_LONG_CYC (`SMCR_RETRY_LONG_MS * 1000 * `SMCR_CLK_MHZ)
`define SMCR_RETRY_SHORT_CYC (`SMCR_RETRY_SHORT_MS * 1000 * `SMCR_CLK_MHZ)
`define SMCR_SWEEP_CYC (`SMCR_SWEEP_MS * 1000 * `SMCR_CLK_MHZ)

`endif

// ---- hdl/smcr_interval_timer.v ----
// Loadable down-counter that flags when its interval has run out.
`timescale 1ns/1ps
module smcr_interval_timer #(
  parameter WIDTH = 24
) (
  // Clock and reset.
  input wire clk_i,
  input wire nrst_i,
  // Control.
  input wire load_i,
  input wire [WIDTH-1:0] load_val_i,
  input wire run_i,
  // Status.
  output wire expired_o
);

  reg [WIDTH-1:0] count_reg; // Cycles left in the interval.

  // A load wins over counting; counting stops at zero.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (load_i) begin
      count_reg <= load_val_i;
    end else if (run_i && (count_reg != {WIDTH{1'b0}})) begin
      count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // The interval has run out while the count rests at zero.
  assign expired_o = (count_reg == {WIDTH{1'b0}});

endmodule // smcr_interval_timer

// ---- testbench/smcr_chk.sv ----
// Concurrent checks on the ports of the monitor control block.
`timescale 1ns/1ps
module smcr_chk #(
  parameter INVERTING = 0,
  parameter QUAL_SHORT_CYC = 25000
) (
  // Clock and reset.
  input wire clk_i,
  input wire nrst_i,
  // Register port.
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  // Converter and output stage.
  input wire conv_start_o,
  input wire [2:0] conv_channel_o,
  input wire [1:0] conv_gain_o,
  input wire trip_i,
  input wire power_down_o,
  input wire out_force_en_o,
  input wire out_force_level_o,
  input wire latched_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Counts how long the raw trip input has been high without a break.
  reg [31:0] trip_run;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trip_run <= 32'h0;
    end else begin
      trip_run <= trip_i ? trip_run + 32'h1 : 32'h0;
    end
  end
  property p_pd_wr;
    reg_wr_i && reg_addr_i == 8'h0a |-> ##2 power_down_o == $past(reg_wdata_i[3], 2);
  endproperty
  a_pd_wr: assert property (p_pd_wr) else $error("power down differs from written bit");
  property p_clr;
    latched_o && reg_wr_i && reg_addr_i == 8'h0a && reg_wdata_i[4] |-> ##[2:3] !latched_o;
  endproperty
  a_clr: assert property (p_clr) else $error("latch not released by clear");
  property p_rd1;
    reg_rd_i && reg_addr_i == 8'h0a |=> !reg_rdata_o[4];
  endproperty
  a_rd1: assert property (p_rd1) else $error("clear bit read back as one");
  property p_rd2;
    reg_rd_i && reg_addr_i == 8'h0b |=> reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[1:0] == 2'h0;
  endproperty
  a_rd2: assert property (p_rd2) else $error("unused delay bits read back set");
  property p_chan;
    conv_start_o |-> conv_channel_o <= 3'h4 && conv_gain_o != 2'h3;
  endproperty
  a_chan: assert property (p_chan) else $error("illegal channel or gain at start");
  property p_pd_idle;
    power_down_o && $past(power_down_o) |-> !conv_start_o;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("conversion started in shutdown");
  property p_qual;
    $rose(latched_o) |-> trip_run >= QUAL_SHORT_CYC;
  endproperty
  a_qual: assert property (p_qual) else $error("latched before qualify delay");
  property p_force;
    latched_o && $past(latched_o) |-> out_force_en_o && out_force_level_o == (INVERTING == 0);
  endproperty
  a_force: assert property (p_force) else $error("latched output level wrong");
  c_temp: cover property (conv_start_o && conv_channel_o == 3'h4);
  c_latch: cover property ($rose(latched_o));
  c_retry: cover property ($fell(latched_o));
endmodule // smcr_chk
bind smcr_control_regs smcr_chk #(.INVERTING(INVERTING), .QUAL_SHORT_CYC(QUAL_SHORT_CYC)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .conv_gain_o(conv_gain_o),
  .trip_i(trip_i), .power_down_o(power_down_o), .out_force_en_o(out_force_en_o),
  .out_force_level_o(out_force_level_o), .latched_o(latched_o));

// ---- testbench/smcr_conv_model.sv ----
// Converter model that answers each start with a done pulse, alternately fast and slow.
`timescale 1ns/1ps
module smcr_conv_model (
  // Clock, reset and handshake.
  input wire clk_i,
  input wire nrst_i,
  input wire start_i,
  output reg done_o
);
  reg [3:0] cnt_reg;
  reg busy_reg;
  reg slow_reg;
  // Alternating delays expose any sequencer that assumes a fixed conversion time.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      slow_reg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy_reg <= 1'b1;
        cnt_reg <= slow_reg ? 4'hc : 4'h1;
        slow_reg <= ~slow_reg;
      end else if (busy_reg && cnt_reg == 4'h0) begin
        busy_reg <= 1'b0;
        done_o <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule // smcr_conv_model

// ---- testbench/test_sense_monitor_control_regs.sv ----
// Self-checking bench for the monitor control registers.
`timescale 1ns/1ps
module test_sense_monitor_control_regs;
  reg clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, trip_i = 0;
  reg [7:0] reg_addr_i = 0, reg_wdata_i = 0, d, v;
  reg [4:0] e;
  wire [7:0] reg_rdata_o;
  wire [2:0] conv_channel_o;
  wire [1:0] conv_gain_o;
  wire conv_start_o, conv_done_i, power_down_o, out_force_en_o, out_force_level_o, latched_o;
  integer error_cnt = 0, tests_run = 0, i, n, q, r;
  always #2 clk_i = ~clk_i;
  // Short delay counts keep the fault sequence quick.
  smcr_control_regs #(.QUAL_LONG_CYC(20), .QUAL_SHORT_CYC(10), .RETRY_LONG_CYC(40),
    .RETRY_SHORT_CYC(30), .SWEEP_CYC(200)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o),
    .conv_gain_o(conv_gain_o), .conv_done_i(conv_done_i), .trip_i(trip_i),
    .power_down_o(power_down_o), .out_force_en_o(out_force_en_o),
    .out_force_level_o(out_force_level_o), .latched_o(latched_o));
  // Inverting variant on the same stimulus; its starts match the first instance.
  wire inv_level_o;
  smcr_control_regs #(.INVERTING(1), .QUAL_LONG_CYC(20), .QUAL_SHORT_CYC(10),
    .RETRY_LONG_CYC(40), .RETRY_SHORT_CYC(30), .SWEEP_CYC(200)) dut_inv (.clk_i(clk_i),
    .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(), .conv_start_o(), .conv_channel_o(),
    .conv_gain_o(), .conv_done_i(conv_done_i), .trip_i(trip_i), .power_down_o(),
    .out_force_en_o(), .out_force_level_o(inv_level_o), .latched_o());
  smcr_conv_model u_conv (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(conv_start_o),
    .done_o(conv_done_i));
  task conclude;
    begin
      $display("errors %0d tests %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [7:0] ex, input [7:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== ex) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] dd);
    begin
      @(posedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, dd};
      @(posedge clk_i) reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] dd);
    begin
      @(posedge clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge clk_i) reg_rd_i <= 1'b0;
      #1 dd = reg_rdata_o;
    end
  endtask
  // Waits for the next converter start; a hang ends the run.
  task wst;
    integer k;
    begin
      for (k = 0; k < 2000; k = k + 1) begin
        @(posedge clk_i);
        #1 if (conv_start_o === 1'b1) k = 5000;
      end
      if (k == 2000) begin
        error_cnt = error_cnt + 1;
        conclude;
      end
    end
  endtask
  // Counts cycles until the latch shows the wanted level.
  task wl(input b, output integer c);
    begin
      for (c = 0; c < 500 && latched_o !== b; c = c + 1) begin
        @(posedge clk_i);
        #1;
      end
      if (c == 500) begin
        error_cnt = error_cnt + 1;
        conclude;
      end
    end
  endtask
  // Expected converter channel and gain for a select code.
  function [4:0] exch(input [2:0] s);
    exch = (s < 3'h3) ? {3'h0, s[1:0]} : {s - 3'h2, 2'h0};
  endfunction
  initial begin
    void'($urandom(50));
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(8'h0a, v); chk("ctl1 rst", 8'h00, v);
    rd(8'h0b, v); chk("ctl2 rst", 8'h00, v);
    rd(8'h3c, v); chk("unmapped", 8'h00, v);
    @(posedge clk_i) trip_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    #1 chk("plain", 8'h00, {6'h0, out_force_en_o, latched_o});
    @(posedge clk_i) trip_i <= 1'b0;
    wr(8'h0b, 8'hff); rd(8'h0b, v); chk("ctl2 msk", 8'h0c, v);
    for (i = 0; i < 6; i = i + 1) begin
      d = $urandom & 8'h0c;
      wr(8'h0b, d); rd(8'h0b, v); chk("ctl2", d, v);
      d = $urandom & 8'h1f;
      wr(8'h0a, d); rd(8'h0a, v); chk("ctl1", d & 8'hef, v);
    end
    // Every non-sweep select code; the first start after the write already sees the new code, and the check follows the second.
    for (i = 0; i < 7; i = i + 1) begin
      wr(8'h0a, i[7:0]); wst; wst; e = exch(i[2:0]);
      chk("chan", {5'h0, e[4:2]}, {5'h0, conv_channel_o});
      if (i < 3) chk("gain", {6'h0, e[1:0]}, {6'h0, conv_gain_o});
    end
    wr(8'h0a, 8'h07); wst;
    for (n = 0; n < 8 && conv_channel_o !== 3'h0; n = n + 1) wst;
    chk("swp gain", 8'h02, {6'h0, conv_gain_o});
    for (i = 1; i < 5; i = i + 1) begin
      wst; chk("sweep", i[7:0], {5'h0, conv_channel_o});
    end
    wr(8'h0a, 8'h08); repeat (3) @(posedge clk_i);
    #1 chk("pwrdn", 8'h01, {7'h0, power_down_o});
    d = $urandom & 8'h0c; wr(8'h0b, d); q = d[3] ? 10 : 20; r = d[2] ? 30 : 40;
    wr(8'h0a, 8'he0);
    @(posedge clk_i) trip_i <= 1'b1;
    #1 chk("cmp qual", 8'h05, {5'h0, out_force_en_o, out_force_level_o, inv_level_o});
    // A short drop before the delay runs out must restart the qualify period.
    repeat (5) @(posedge clk_i);
    trip_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    trip_i <= 1'b1;
    wl(1'b1, n); chk("qual", 8'h01, {7'h0, n >= q && n <= q + 6});
    wl(1'b0, n); chk("retry", 8'h01, {7'h0, n >= r - 2 && n <= r + 2});
    wl(1'b1, n); chk("requal", 8'h01, {7'h0, n >= q - 1 && n <= q + 6});
    wr(8'h0a, 8'hf0); repeat (2) @(posedge clk_i);
    #1 chk("clear", 8'h00, {7'h0, latched_o});
    wr(8'h0a, 8'h60); wl(1'b1, n);
    #4 chk("amp", 8'h06, {5'h0, out_force_en_o, out_force_level_o, inv_level_o});
    @(posedge clk_i) nrst_i <= 1'b0;
    @(posedge clk_i) nrst_i <= 1'b1;
    rd(8'h0a, v); chk("ctl1 rs2", 8'h00, v);
    rd(8'h0b, v); chk("ctl2 rs2", 8'h00, v);
    @(posedge clk_i) trip_i <= 1'b0;
    conclude;
  end
endmodule // test_sense_monitor_control_regs
